// *** rtl/bsr_strap_regs.sv ***
// Boot strap register bank: capture, indexed I/O access and decoded outputs.
`timescale 1ns/1ps
`default_nettype none
module bsr_strap_regs #(
    parameter int unsigned SETTLE_CYCLES = bsr_pkg::STRAP_SETTLE_CYCLES
) (
    input  wire logic                     core_clk_i,
    input  wire logic                     sys_rst_i,
    input  wire bsr_pkg::bsr_strap_pins_t strap_pins_i,
    input  wire bsr_pkg::bsr_io_req_t     io_req_i,
    output var  logic [7:0]               io_rdata_o,
    output var  logic                     io_rvalid_o,
    output var  logic                     straps_valid_o,
    output var  logic                     bus_clock_pll_high_range_o,
    output var  logic                     bus_clock_pll_reserved_o,
    output var  logic                     isa_enable_o,
    output var  logic                     pcmcia_enable_o,
    output var  logic                     local_bus_enable_o,
    output var  logic                     expansion_mode_reserved_o,
    output var  logic                     memory_host_sync_o,
    output var  logic [2:0]               bus_clock_divisor_o,
    output var  logic [1:0]               cpu_multiplier_o,
    output var  logic                     boot_width_16_o,
    output var  logic [6:0]               host_clock_mhz_o,
    output var  logic                     dot_clock_output_en_o,
    output var  logic                     memory_clock_output_en_o,
    output var  logic                     host_clock_output_en_o,
    output var  logic                     parallel_port_enable_o,
    output var  logic                     keyboard_enable_o,
    output var  logic                     serial_port_one_enable_o,
    output var  logic                     serial_port_two_enable_o,
    output var  logic [1:0]               deskew_range_o
);
    import bsr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    bsr_strap_pins_t pins_sync;
    logic [$bits(bsr_strap_pins_t)-1:0] pins_sync_vec;

    bsr_sync #(
        .WIDTH    ($bits(bsr_strap_pins_t))
    ) u_sync (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .async_i    (strap_pins_i),
        .sync_o     (pins_sync_vec)
    );

    assign pins_sync = bsr_strap_pins_t'(pins_sync_vec);

    ////////////////////////////////////////////////////////////////////////////
    // Capture sequencer.

    localparam int unsigned CNT_W = $clog2(SETTLE_CYCLES + 2);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES);

    bsr_cap_state_t   cap_state_q;
    logic [CNT_W-1:0] settle_cnt_q;
    logic             capture;

    // The synchroniser needs two cycles after reset to fill with real pin
    // levels, so the count runs one past the settle time before sampling.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cap_state_q  <= CAP_WAIT;
            settle_cnt_q <= '0;
        end
        else
        begin
            case (cap_state_q)
                CAP_WAIT:
                begin
                    cap_state_q  <= CAP_SETTLE;
                    settle_cnt_q <= '0;
                end
                CAP_SETTLE:
                begin
                    if (settle_cnt_q == SETTLE_LAST)
                        cap_state_q <= CAP_DONE;
                    else
                        settle_cnt_q <= settle_cnt_q + 1'b1;
                end
                CAP_DONE:
                    cap_state_q <= CAP_DONE;
                default:
                    cap_state_q <= CAP_WAIT;
            endcase
        end
    end

    assign capture = (cap_state_q == CAP_SETTLE) && (settle_cnt_q == SETTLE_LAST);

    ////////////////////////////////////////////////////////////////////////////
    // Strap registers.

    logic [7:0] bus_clock_mode_q;
    logic [7:0] cpu_mult_boot_q;
    logic [7:0] clock_pins_q;
    logic [7:0] host_synth_q;
    logic [1:0] host_speed_q;
    logic [1:0] deskew_q;
    logic [7:0] index_q;
    logic       data_wr;

    assign data_wr = io_req_i.wr && (io_req_i.addr == IO_DATA_PORT);

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            bus_clock_mode_q <= STRAP_REG_RESET;
            cpu_mult_boot_q  <= STRAP_REG_RESET;
            host_synth_q     <= STRAP_REG_RESET;
            host_speed_q     <= '0;
            deskew_q         <= '0;
        end
        else if (capture)
        begin
            bus_clock_mode_q <= {pins_sync.bus_clock_pll_range_straps,
                                 pins_sync.expansion_mode_straps, 1'b0,
                                 pins_sync.memory_host_sync_strap,
                                 pins_sync.bus_clock_divisor_high_strap,
                                 pins_sync.bus_clock_divisor_low_strap};
            cpu_mult_boot_q  <= {pins_sync.cpu_multiplier_strap_b,
                                 pins_sync.cpu_multiplier_strap_a, 5'h00,
                                 pins_sync.boot_width_strap};
            host_synth_q     <= {2'h0, pins_sync.host_synth_select_straps,
                                 3'h0};
            host_speed_q     <= {pins_sync.host_speed_strap_high,
                                 pins_sync.host_speed_strap_low};
            deskew_q         <= {pins_sync.deskew_strap_a,
                                 pins_sync.deskew_strap_b};
        end
    end

    // Capture wins over a software write in the same cycle, so the dot-clock
    // bit always starts from the board strapping.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            clock_pins_q <= STRAP_REG_RESET;
        else if (capture)
            clock_pins_q <= {pins_sync.parallel_port_enable_strap,
                             pins_sync.keyboard_enable_strap, 1'b0,
                             pins_sync.dot_clock_direction_strap,
                             pins_sync.memory_clock_output_strap,
                             pins_sync.host_clock_direction_strap,
                             pins_sync.serial_port_one_enable_strap,
                             pins_sync.serial_port_two_enable_strap};
        else if (data_wr && (index_q == IDX_CLOCK_PINS_ENABLE))
            clock_pins_q <= (clock_pins_q & ~CLOCK_PINS_WMASK)
                          | (io_req_i.wdata & CLOCK_PINS_WMASK);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Index/data port access.

    function automatic logic [7:0] reg_read(input logic [7:0] idx,
                                            input logic [7:0] r4a,
                                            input logic [7:0] r4b,
                                            input logic [7:0] r4c,
                                            input logic [7:0] r5f);
        if (idx == IDX_BUS_CLOCK_MODE)
            return r4a;
        else if (idx == IDX_CPU_MULT_BOOT)
            return r4b;
        else if (idx == IDX_CLOCK_PINS_ENABLE)
            return r4c;
        else if (idx == IDX_HOST_CLOCK_SYNTH)
            return r5f;
        else
            return UNMAPPED_READ;
    endfunction : reg_read

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
            index_q <= INDEX_RESET;
        else if (io_req_i.wr && (io_req_i.addr == IO_INDEX_PORT))
            index_q <= io_req_i.wdata;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            io_rdata_o  <= 8'h00;
            io_rvalid_o <= 1'b0;
        end
        else
        begin
            io_rvalid_o <= io_req_i.rd;
            if (io_req_i.rd && (io_req_i.addr == IO_DATA_PORT))
                io_rdata_o <= reg_read(index_q, bus_clock_mode_q, cpu_mult_boot_q,
                                       clock_pins_q, host_synth_q);
            else if (io_req_i.rd && (io_req_i.addr == IO_INDEX_PORT))
                io_rdata_o <= index_q;
            else if (io_req_i.rd)
                io_rdata_o <= UNMAPPED_READ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Decoded configuration outputs, registered from the strap registers, and straps_valid_o, registered from the capture state.

    logic [1:0] pll_f;
    logic [1:0] mode_f;
    logic [1:0] mult_f;
    logic [2:0] synth_f;

    assign pll_f   = bus_clock_mode_q[POS_PLL_RANGE +: 2];
    assign mode_f  = bus_clock_mode_q[POS_EXP_MODE +: 2];
    assign mult_f  = cpu_mult_boot_q[POS_MULT +: 2];
    assign synth_f = host_synth_q[POS_SYNTH_SEL +: 3];

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            bus_clock_pll_high_range_o <= 1'b0;
            bus_clock_pll_reserved_o   <= 1'b0;
            isa_enable_o               <= 1'b0;
            pcmcia_enable_o            <= 1'b0;
            local_bus_enable_o         <= 1'b0;
            expansion_mode_reserved_o  <= 1'b0;
            memory_host_sync_o         <= 1'b0;
            bus_clock_divisor_o        <= BUS_DIV_BY_4;
        end
        else
        begin
            bus_clock_pll_high_range_o <= (pll_f == 2'b01);
            bus_clock_pll_reserved_o   <= pll_f[1];
            isa_enable_o               <= (mode_f == 2'b00);
            pcmcia_enable_o            <= (mode_f == 2'b01);
            local_bus_enable_o         <= (mode_f == 2'b10);
            expansion_mode_reserved_o  <= (mode_f == 2'b11);
            memory_host_sync_o         <= bus_clock_mode_q[POS_MEM_SYNC];
            if (!bus_clock_mode_q[POS_DIV_HIGH])
                bus_clock_divisor_o <= BUS_DIV_BY_4;
            else if (!bus_clock_mode_q[POS_DIV_LOW])
                bus_clock_divisor_o <= BUS_DIV_BY_3;
            else
                bus_clock_divisor_o <= BUS_DIV_BY_2;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cpu_multiplier_o <= CPU_MULT_RSV;
            boot_width_16_o  <= 1'b0;
            host_clock_mhz_o <= HOST_MHZ_RSV;
            deskew_range_o   <= DESKEW_RSV;
        end
        else
        begin
            if (mult_f == 2'b01)
                cpu_multiplier_o <= CPU_MULT_X1;
            else if (mult_f == 2'b11)
                cpu_multiplier_o <= CPU_MULT_X2;
            else
                cpu_multiplier_o <= CPU_MULT_RSV;
            boot_width_16_o <= cpu_mult_boot_q[POS_BOOT_WIDTH];
            // Table entries exist only for both speed straps low.
            if (host_speed_q != 2'b00)
                host_clock_mhz_o <= HOST_MHZ_RSV;
            else if (synth_f == 3'b000)
                host_clock_mhz_o <= HOST_MHZ_25;
            else if (synth_f == 3'b001)
                host_clock_mhz_o <= HOST_MHZ_50;
            else if (synth_f == 3'b010)
                host_clock_mhz_o <= HOST_MHZ_60;
            else if (synth_f == 3'b011)
                host_clock_mhz_o <= HOST_MHZ_66;
            else
                host_clock_mhz_o <= HOST_MHZ_RSV;
            if (deskew_q == 2'b10)
                deskew_range_o <= DESKEW_33_64;
            else if (deskew_q == 2'b01)
                deskew_range_o <= DESKEW_64_133;
            else
                deskew_range_o <= DESKEW_RSV;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            straps_valid_o           <= 1'b0;
            dot_clock_output_en_o    <= 1'b0;
            memory_clock_output_en_o <= 1'b0;
            host_clock_output_en_o   <= 1'b0;
            parallel_port_enable_o   <= 1'b0;
            keyboard_enable_o        <= 1'b0;
            serial_port_one_enable_o <= 1'b0;
            serial_port_two_enable_o <= 1'b0;
        end
        else
        begin
            straps_valid_o           <= (cap_state_q == CAP_DONE);
            dot_clock_output_en_o    <= clock_pins_q[POS_DOT_CLOCK];
            memory_clock_output_en_o <= clock_pins_q[POS_MEM_CLOCK];
            host_clock_output_en_o   <= clock_pins_q[POS_HOST_CLOCK];
            parallel_port_enable_o   <= clock_pins_q[POS_PARALLEL];
            keyboard_enable_o        <= clock_pins_q[POS_KEYBOARD];
            serial_port_one_enable_o <= clock_pins_q[POS_SERIAL_ONE];
            serial_port_two_enable_o <= clock_pins_q[POS_SERIAL_TWO];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    chk_capture_loads: assert property (capture |=> bus_clock_mode_q[7:6] == $past(pins_sync.bus_clock_pll_range_straps))
        else $error("Strap register did not load captured pins.");

    chk_hold_after: assert property (cap_state_q == CAP_DONE |=> $stable(bus_clock_mode_q) && $stable(cpu_mult_boot_q) && $stable(host_synth_q))
        else $error("Read-only strap register changed after capture.");

    chk_index_read: assert property (io_req_i.rd && io_req_i.addr == IO_DATA_PORT && index_q == IDX_CPU_MULT_BOOT |=> io_rvalid_o && io_rdata_o == $past(cpu_mult_boot_q))
        else $error("Data port read returned wrong register.");

    chk_rsv_zero: assert property (bus_clock_mode_q[3] == 1'b0 && cpu_mult_boot_q[5:1] == 5'h00 && host_synth_q[7:6] == 2'h0 && clock_pins_q[5] == 1'b0)
        else $error("Reserved strap bit is not zero.");

    chk_mode_onehot: assert property (!$past(sys_rst_i) |-> $onehot({isa_enable_o, pcmcia_enable_o, local_bus_enable_o, expansion_mode_reserved_o}))
        else $error("Expansion mode enables not one-hot.");

    chk_divisor: assert property (bus_clock_mode_q[1:0] == 2'b10 |=> bus_clock_divisor_o == BUS_DIV_BY_3)
        else $error("Bus clock divisor decode wrong.");

    chk_dot_write: assert property (data_wr && index_q == IDX_CLOCK_PINS_ENABLE && !capture |=> clock_pins_q == (($past(clock_pins_q) & 8'hef) | ($past(io_req_i.wdata) & 8'h10)))
        else $error("Clock pin register write not masked to bit 4.");

    chk_ro_write: assert property (data_wr && index_q != IDX_CLOCK_PINS_ENABLE && !capture |=> $stable(bus_clock_mode_q) && $stable(clock_pins_q))
        else $error("Write to read-only register had effect.");

    chk_host_freq: assert property (host_speed_q == 2'b00 && synth_f == 3'b011 |=> host_clock_mhz_o == HOST_MHZ_66)
        else $error("Host clock frequency decode wrong.");

    chk_deskew_out: assert property (deskew_q == 2'b01 |=> deskew_range_o == DESKEW_64_133)
        else $error("Deskew range decode wrong.");

    chk_dot_follow: assert property (##1 $changed(clock_pins_q[POS_DOT_CLOCK]) |=> dot_clock_output_en_o == $past(clock_pins_q[POS_DOT_CLOCK]))
        else $error("Dot clock enable does not follow register.");

    chk_capture_time: assert property ($fell(sys_rst_i) |-> ##[1:300] capture)
        else $error("Straps not captured in time.");

    cov_capture: cover property (capture);
    cov_dot_write: cover property (data_wr && index_q == IDX_CLOCK_PINS_ENABLE);
    cov_read_synth: cover property (io_req_i.rd && io_req_i.addr == IO_DATA_PORT && index_q == IDX_HOST_CLOCK_SYNTH);
    cov_unmapped: cover property (io_req_i.rd && io_req_i.addr == IO_DATA_PORT && index_q == 8'h4d);

endmodule : bsr_strap_regs
`default_nettype wire

// *** rtl/bsr_pkg.sv ***
// Shared constants and types for the boot strap register bank.
package bsr_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // I/O ports of the indexed configuration scheme.
    localparam logic [15:0] IO_INDEX_PORT = 16'h0022;
    localparam logic [15:0] IO_DATA_PORT  = 16'h0023;

    // Register indices written to the index port.
    localparam logic [7:0] IDX_BUS_CLOCK_MODE    = 8'h4a;
    localparam logic [7:0] IDX_CPU_MULT_BOOT     = 8'h4b;
    localparam logic [7:0] IDX_CLOCK_PINS_ENABLE = 8'h4c;
    localparam logic [7:0] IDX_HOST_CLOCK_SYNTH  = 8'h5f;

    // Reset values before the straps are captured, the reset index and the value read from unmapped indices.
    localparam logic [7:0] STRAP_REG_RESET = 8'h00;
    localparam logic [7:0] INDEX_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_READ   = 8'h00;

    // Field positions.
    localparam int unsigned POS_PLL_RANGE   = 6;
    localparam int unsigned POS_EXP_MODE    = 4;
    localparam int unsigned POS_MEM_SYNC    = 2;
    localparam int unsigned POS_DIV_HIGH    = 1;
    localparam int unsigned POS_DIV_LOW     = 0;
    localparam int unsigned POS_MULT        = 6;
    localparam int unsigned POS_BOOT_WIDTH  = 0;
    localparam int unsigned POS_SYNTH_SEL   = 3;
    localparam int unsigned POS_PARALLEL    = 7;
    localparam int unsigned POS_KEYBOARD    = 6;
    localparam int unsigned POS_DOT_CLOCK   = 4;
    localparam int unsigned POS_MEM_CLOCK   = 3;
    localparam int unsigned POS_HOST_CLOCK  = 2;
    localparam int unsigned POS_SERIAL_ONE  = 1;
    localparam int unsigned POS_SERIAL_TWO  = 0;

    // Only the dot-clock direction bit of the clock pin register is writable.
    localparam logic [7:0] CLOCK_PINS_WMASK = 8'h10;

    // Decoded values.
    localparam logic [2:0] BUS_DIV_BY_4  = 3'h4;
    localparam logic [2:0] BUS_DIV_BY_3  = 3'h3;
    localparam logic [2:0] BUS_DIV_BY_2  = 3'h2;
    localparam logic [1:0] CPU_MULT_X1   = 2'h1;
    localparam logic [1:0] CPU_MULT_X2   = 2'h2;
    localparam logic [1:0] CPU_MULT_RSV  = 2'h0;
    localparam logic [6:0] HOST_MHZ_25   = 7'h19;
    localparam logic [6:0] HOST_MHZ_50   = 7'h32;
    localparam logic [6:0] HOST_MHZ_60   = 7'h3c;
    localparam logic [6:0] HOST_MHZ_66   = 7'h42;
    localparam logic [6:0] HOST_MHZ_RSV  = 7'h00;
    localparam logic [1:0] DESKEW_33_64  = 2'h1;
    localparam logic [1:0] DESKEW_64_133 = 2'h2;
    localparam logic [1:0] DESKEW_RSV    = 2'h0;

    // Strap sampling point after reset release.
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned STRAP_SETTLE_NS = 100;
    localparam int unsigned STRAP_SETTLE_CYCLES =
        (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        CAP_WAIT    = 2'b00,
        CAP_SETTLE  = 2'b01,
        CAP_DONE    = 2'b11
    } bsr_cap_state_t;

    typedef struct packed {
        logic [1:0] bus_clock_pll_range_straps;
        logic [1:0] expansion_mode_straps;
        logic       memory_host_sync_strap;
        logic       bus_clock_divisor_high_strap;
        logic       bus_clock_divisor_low_strap;
        logic       cpu_multiplier_strap_b;
        logic       cpu_multiplier_strap_a;
        logic       boot_width_strap;
        logic [2:0] host_synth_select_straps;
        logic       host_speed_strap_high;
        logic       host_speed_strap_low;
        logic       parallel_port_enable_strap;
        logic       keyboard_enable_strap;
        logic       dot_clock_direction_strap;
        logic       memory_clock_output_strap;
        logic       host_clock_direction_strap;
        logic       serial_port_one_enable_strap;
        logic       serial_port_two_enable_strap;
        logic       deskew_strap_a;
        logic       deskew_strap_b;
    } bsr_strap_pins_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bsr_io_req_t;

endpackage : bsr_pkg

// *** rtl/bsr_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module bsr_sync #(
    parameter int unsigned WIDTH = 24
) (
    input  wire logic             core_clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : bsr_sync
`default_nettype wire

// *** bench/bsr_board_straps.sv ***
// Board pull resistors on the strap pins.
`timescale 1ns/1ps
`default_nettype none
module bsr_board_straps (
    input  wire logic [23:0]            fit_i,
    output var  bsr_pkg::bsr_strap_pins_t pins_o
);
    // Every strap has a resistor fitted, so no pin ever floats.
    assign pins_o = bsr_pkg::bsr_strap_pins_t'(fit_i);
endmodule : bsr_board_straps
`default_nettype wire

// *** bench/boot_strap_registers_tb.sv ***
// Self-checking bench for the boot strap register bank.
`timescale 1ns/1ps
`default_nettype none
module boot_strap_registers_tb;
    import bsr_pkg::*;
    localparam logic [7:0]  IDX [4] = '{8'h4a, 8'h4b, 8'h4c, 8'h5f};
    localparam logic [23:0] PAT [5] = '{24'h4799fd, 24'h9cd006, 24'h230d58, 24'hf00003,
                                        24'h5b0837};
    logic            clk = 1'b0;
    logic            rst = 1'b1;
    logic [23:0]     fit = 24'h0;
    bsr_io_req_t     req = '0;
    bsr_strap_pins_t pins;
    logic [7:0]      rdata;
    logic [7:0]      exp_r [4];
    logic [6:0]      mhz;
    logic [2:0]      div;
    logic [1:0]      mult, dsk;
    logic            rvalid, valid, pll_hi, pll_rsv, isa, pcm, lcl, mrsv, sync, bw16;
    logic            dot, mem, host, par, kbd, s1, s2;
    int              fail_count = 0;
    int              comparisons = 0;
    always #5 clk = ~clk;
    bsr_board_straps u_board (.fit_i(fit), .pins_o(pins));
    bsr_strap_regs #(.SETTLE_CYCLES(1)) u_dut (
        .core_clk_i(clk), .sys_rst_i(rst), .strap_pins_i(pins), .io_req_i(req),
        .io_rdata_o(rdata), .io_rvalid_o(rvalid), .straps_valid_o(valid),
        .bus_clock_pll_high_range_o(pll_hi), .bus_clock_pll_reserved_o(pll_rsv),
        .isa_enable_o(isa), .pcmcia_enable_o(pcm), .local_bus_enable_o(lcl),
        .expansion_mode_reserved_o(mrsv), .memory_host_sync_o(sync),
        .bus_clock_divisor_o(div), .cpu_multiplier_o(mult), .boot_width_16_o(bw16),
        .host_clock_mhz_o(mhz), .dot_clock_output_en_o(dot), .memory_clock_output_en_o(mem),
        .host_clock_output_en_o(host), .parallel_port_enable_o(par), .keyboard_enable_o(kbd),
        .serial_port_one_enable_o(s1), .serial_port_two_enable_o(s2), .deskew_range_o(dsk));
    ////////////////////////////////////////////////////////////////////////////
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic io(input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk) req <= '{rd: r, wr: !r, addr: a, wdata: d};
        @(posedge clk) req <= '0;
        #1;
        if (r)
            cmp("rvalid", 8'h01, {7'h0, rvalid});
    endtask : io
    task automatic reg_rd(input logic [7:0] i, output logic [7:0] v);
        io(1'b0, IO_INDEX_PORT, i);
        io(1'b1, IO_DATA_PORT, 8'h00);
        v = rdata;
    endtask : reg_rd
    task automatic scen_capture(input logic [23:0] f);
        logic [7:0] v;
        logic [6:0] hz;
        @(posedge clk) fit <= f;
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 40 && valid !== 1'b1; i++) @(negedge clk);
        cmp("valid", 8'h01, {7'h0, valid});
        // Flipping every pin after capture proves the levels are held.
        @(posedge clk) fit <= ~f;
        repeat (4) @(negedge clk);
        exp_r = '{{f[23:20], 1'b0, f[19:17]}, {f[16:15], 5'h0, f[14]},
                  {f[8:7], 1'b0, f[6:2]}, {2'h0, f[13:11], 3'h0}};
        for (int i = 0; i < 4; i++)
        begin
            reg_rd(IDX[i], v);
            cmp("reg", exp_r[i], v);
        end
        hz = f[12] ? (f[11] ? HOST_MHZ_66 : HOST_MHZ_60) : (f[11] ? HOST_MHZ_50 : HOST_MHZ_25);
        if (f[13] | f[10] | f[9])
            hz = HOST_MHZ_RSV;
        cmp("pll", {6'h0, f[23:22] == 2'h1, f[23]}, {6'h0, pll_hi, pll_rsv});
        cmp("mode", {4'h0, 4'h8 >> f[21:20]}, {4'h0, isa, pcm, lcl, mrsv});
        cmp("div", !f[18] ? 8'h4 : (f[17] ? 8'h2 : 8'h3), {5'h0, div});
        cmp("mult", {5'h0, f[14], f[15] & f[16], f[15] & !f[16]}, {5'h0, bw16, mult});
        cmp("mhz", {1'b0, hz}, {1'b0, mhz});
        cmp("en", {f[19], f[8:2]}, {sync, par, kbd, dot, mem, host, s1, s2});
        cmp("deskew", {6'h0, f[1:0] == 2'h1, f[1:0] == 2'h2}, {6'h0, dsk});
    endtask : scen_capture
    task automatic scen_write(input logic [23:0] f);
        logic [7:0] v;
        for (int i = 0; i < 4; i++)
        begin
            io(1'b0, IO_INDEX_PORT, IDX[i]);
            io(1'b0, IO_DATA_PORT, ~exp_r[i]);
            reg_rd(IDX[i], v);
            cmp("wr reg", (i == 2) ? exp_r[i] ^ 8'h10 : exp_r[i], v);
        end
        repeat (2) @(negedge clk);
        cmp("dot", {7'h0, !f[6]}, {7'h0, dot});
        reg_rd(8'h4d, v);
        cmp("unmapped", UNMAPPED_READ, v);
        io(1'b1, IO_INDEX_PORT, 8'h00);
        cmp("index", 8'h4d, rdata);
    endtask : scen_write
    task automatic complete_run;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        for (int k = 0; k < 5; k++)
        begin
            scen_capture(PAT[k]);
            scen_write(PAT[k]);
        end
        complete_run();
    end
    initial
    begin
        #50000;
        fail_count++;
        complete_run();
    end
endmodule : boot_strap_registers_tb
`default_nettype wire
